// ### rtl/power_mode_clock_manager.v
// Power mode and clock manager: mode machine, PLL model, dividers,
// regulator setting, APB register slave.
// Assumes an APB master on pclk; wake and input clock pins are asynchronous.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "pwr_clk_defines.vh"

// Summary of operation
// - Power-up enters full-on mode: PLL enabled and not bypassed.
// - Active mode bypasses PLL; clocks come straight from the input clock.
// - New multiplier applies only after the lock wait counter expires.
// - Active mode still grants system DMA to level-one memory.
// - Sleep gates core clock, keeps PLL and system clock running.
// - Interrupt in sleep wakes to full-on, or active when bypass set.
// - Sleep refuses system DMA to level-one memory.
// - Deep sleep gates core and system clocks and disables the PLL.
// - Only reset or RTC interrupt leaves deep sleep, into full-on.
// - Deep sleep blocks RTC access to internal and external resources.
// - Regulator level in 50 mV steps; can be disabled and bypassed.
// - Multiplier 1 to 31, reset default ten, changeable at runtime.
// - Peripherals are clocked from the system clock, not the core clock.
// - System clock divides PLL output by the four-bit field value.
// - System divider limited to one through fifteen.
// - System divider writes apply without waiting for PLL lock.
// - Core divider field selects one, two, four or eight.
module power_mode_clock_manager (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Clock input and wake events (asynchronous)
  input wire input_clk_pin,
  input wire wake_irq,
  input wire rtc_wake_irq,
  input wire reset_wake_irq,
  // Access requests
  input wire dma_req,
  input wire rtc_access_req,
  output reg dma_grant,
  output reg rtc_access_grant,
  // Generated clocks
  output reg core_clk,
  output reg system_clk,
  // PLL and regulator controls
  output reg pll_enable,
  output reg pll_bypass,
  output reg [4:0] regulator_level,
  output reg regulator_enable,
  output reg regulator_bypass,
  output reg [1:0] op_mode
);

  localparam FULL_ON = `MODE_FULL_ON;
  localparam ACTIVE = `MODE_ACTIVE;
  localparam SLEEP = `MODE_SLEEP;
  localparam DEEP_SLEEP = `MODE_DEEP_SLEEP;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [3:0] core_ratio;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: core_ratio = 4'h1;
        2'h1: core_ratio = 4'h2;
        2'h2: core_ratio = 4'h4;
        default: core_ratio = 4'h8;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [1:0] refclk_sync, irq_sync, rtc_sync, rst_sync, rtcreq_sync;
  reg refclk_prev;
  wire refclk_edge = refclk_sync[1] ^ refclk_prev;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refclk_sync <= 2'h0;
      irq_sync <= 2'h0;
      rtc_sync <= 2'h0;
      rst_sync <= 2'h0;
      rtcreq_sync <= 2'h0;
      refclk_prev <= 1'b0;
    end else begin
      refclk_sync <= {refclk_sync[0], input_clk_pin};
      irq_sync <= {irq_sync[0], wake_irq};
      rtc_sync <= {rtc_sync[0], rtc_wake_irq};
      rst_sync <= {rst_sync[0], reset_wake_irq};
      rtcreq_sync <= {rtcreq_sync[0], rtc_access_req};
      refclk_prev <= refclk_sync[1];
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg skip_bit;
  reg [4:0] mult_req, mult_act;
  reg [3:0] sys_sel;
  reg [1:0] core_sel;
  reg [15:0] lock_count, lock_wait_counter;
  reg locked;
  reg [1:0] mode, next_mode;

  wire apb_write = psel & penable & pready & pwrite;
  wire wr_pll = apb_write && paddr == `OFS_PLL_CTRL;
  wire wr_div = apb_write && paddr == `OFS_DIVIDE;
  wire wr_mode = apb_write && paddr == `OFS_MODE;
  wire wr_reg = apb_write && paddr == `OFS_REGULATOR;
  wire wr_lock = apb_write && paddr == `OFS_LOCK_COUNT;
  wire [4:0] wr_mult = pwdata[`MULT_MSB:`MULT_LSB];
  wire [3:0] wr_sys_sel = pwdata[`SYSDIV_MSB:`SYSDIV_LSB];
  wire [1:0] wr_cmd = pwdata[`MODE_CMD_MSB:`MODE_CMD_LSB];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_bit <= 1'b0;
      mult_req <= `MULT_RESET;
      sys_sel <= `SYSDIV_RESET;
      core_sel <= `COREDIV_RESET;
      lock_count <= `LOCK_COUNT_RESET;
      regulator_level <= `REG_LEVEL_RESET;
      regulator_enable <= 1'b1;
      regulator_bypass <= 1'b0;
    end else begin
      if (wr_pll) begin
        skip_bit <= pwdata[`PLL_SKIP_BIT];
        if (wr_mult != 5'h00)
          mult_req <= wr_mult;
      end
      if (wr_div) begin
        if (wr_sys_sel != 4'h0)
          sys_sel <= wr_sys_sel;
        core_sel <= pwdata[`COREDIV_MSB:`COREDIV_LSB];
      end
      if (wr_reg) begin
        regulator_level <= pwdata[`REG_LEVEL_MSB:`REG_LEVEL_LSB];
        regulator_enable <= ~pwdata[`REG_DISABLE_BIT];
        regulator_bypass <= pwdata[`REG_BYPASS_BIT];
      end
      if (wr_lock)
        lock_count <= pwdata[`LOCK_MSB:`LOCK_LSB];
    end
  end

  // ----------------------------------------
  // Lock wait and multiplier hand-over
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mult_act <= `MULT_RESET;
      lock_wait_counter <= 16'h0000;
      locked <= 1'b1;
    end else if (wr_pll && wr_mult != 5'h00) begin
      lock_wait_counter <= lock_count;
      locked <= 1'b0;
    end else if (!locked) begin
      if (lock_wait_counter == 16'h0000) begin
        mult_act <= mult_req;
        locked <= 1'b1;
      end else
        lock_wait_counter <= lock_wait_counter - 16'h0001;
    end
  end

  // ----------------------------------------
  // Operating mode machine
  // ----------------------------------------
  always @* begin
    next_mode = mode;
    case (mode)
      FULL_ON, ACTIVE: begin
        if (wr_mode && wr_cmd == `CMD_SLEEP)
          next_mode = SLEEP;
        else if (wr_mode && wr_cmd == `CMD_DEEP_SLEEP)
          next_mode = DEEP_SLEEP;
        else
          next_mode = skip_bit ? ACTIVE : FULL_ON;
      end
      SLEEP: begin
        if (irq_sync[1] | rtc_sync[1] | rst_sync[1])
          next_mode = skip_bit ? ACTIVE : FULL_ON;
      end
      DEEP_SLEEP: begin
        if (rtc_sync[1] | rst_sync[1])
          next_mode = FULL_ON;
      end
      default: next_mode = FULL_ON;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mode <= FULL_ON;
    else
      mode <= next_mode;
  end

  // ----------------------------------------
  // PLL model and clock source
  // ----------------------------------------
  // Pclk edges stand in for VCO half periods; in bypass both pin edges tick.
  // Multiplier is reported, not synthesised, since pclk is the fastest clock.
  wire src_tick = pll_bypass ? refclk_edge : pll_enable;
  wire core_run = mode == FULL_ON || mode == ACTIVE;
  wire sys_run = mode != DEEP_SLEEP;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_enable <= 1'b1;
      pll_bypass <= 1'b0;
      op_mode <= FULL_ON;
    end else begin
      // Keeps ticking until both clocks end low, else they would freeze high
      pll_enable <= next_mode != DEEP_SLEEP || core_clk || system_clk;
      pll_bypass <= next_mode == ACTIVE;
      op_mode <= next_mode;
    end
  end

  // ----------------------------------------
  // Glitch-free dividers
  // ----------------------------------------
  // Output toggles every N source ticks; a new N is latched only on a
  // toggle, so no half period is ever cut short.
  reg [3:0] core_cnt, core_div, sys_cnt, sys_div;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_cnt <= 4'h0;
      core_div <= core_ratio(`COREDIV_RESET);
      core_clk <= 1'b0;
    end else if (src_tick && (core_clk || core_run)) begin
      if (core_cnt >= core_div - 4'h1) begin
        core_cnt <= 4'h0;
        core_clk <= ~core_clk;
        core_div <= core_ratio(core_sel);
      end else
        core_cnt <= core_cnt + 4'h1;
    end
  end

  // All peripherals take system_clk; core_clk never feeds them.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_cnt <= 4'h0;
      sys_div <= `SYSDIV_RESET;
      system_clk <= 1'b0;
    end else if (src_tick && (system_clk || sys_run)) begin
      if (sys_cnt >= sys_div - 4'h1) begin
        sys_cnt <= 4'h0;
        system_clk <= ~system_clk;
        sys_div <= sys_sel;
      end else
        sys_cnt <= sys_cnt + 4'h1;
    end
  end

  // ----------------------------------------
  // Access grants
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_grant <= 1'b0;
      rtc_access_grant <= 1'b0;
    end else begin
      dma_grant <= dma_req && core_run;
      rtc_access_grant <= rtcreq_sync[1] && mode != DEEP_SLEEP;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // One wait state keeps pready registered.
  reg [31:0] rd_value;
  reg rd_hit;

  always @* begin
    rd_value = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `OFS_PLL_CTRL: begin
        rd_value[`PLL_SKIP_BIT] = skip_bit;
        rd_value[`MULT_MSB:`MULT_LSB] = mult_req;
      end
      `OFS_DIVIDE: begin
        rd_value[`SYSDIV_MSB:`SYSDIV_LSB] = sys_sel;
        rd_value[`COREDIV_MSB:`COREDIV_LSB] = core_sel;
      end
      `OFS_MODE: rd_value[`MODE_CMD_MSB:`MODE_CMD_LSB] = mode;
      `OFS_REGULATOR: begin
        rd_value[`REG_LEVEL_MSB:`REG_LEVEL_LSB] = regulator_level;
        rd_value[`REG_DISABLE_BIT] = ~regulator_enable;
        rd_value[`REG_BYPASS_BIT] = regulator_bypass;
      end
      `OFS_LOCK_COUNT: rd_value[`LOCK_MSB:`LOCK_LSB] = lock_count;
      `OFS_STATUS: begin
        rd_value[`MODE_CMD_MSB:`MODE_CMD_LSB] = mode;
        rd_value[`STAT_LOCKED_BIT] = locked;
        rd_value[`STAT_MACT_MSB:`STAT_MACT_LSB] = mult_act;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= ~rd_hit;
      prdata <= pwrite ? 32'h0000_0000 : rd_value;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// ### rtl/pwr_clk_defines.vh
// Constants for the power mode and clock manager: register map,
// field positions, reset values, mode codes and counts.
// Assumes inclusion by bare name from the rtl folder.
`ifndef PWR_CLK_DEFINES_VH
`define PWR_CLK_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_PLL_CTRL 8'h00
`define OFS_DIVIDE 8'h04
`define OFS_MODE 8'h08
`define OFS_REGULATOR 8'h0c
`define OFS_LOCK_COUNT 8'h10
`define OFS_STATUS 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PLL_SKIP_BIT 0
`define MULT_LSB 1
`define MULT_MSB 5
`define SYSDIV_LSB 0
`define SYSDIV_MSB 3
`define COREDIV_LSB 4
`define COREDIV_MSB 5
`define MODE_CMD_LSB 0
`define MODE_CMD_MSB 1
`define REG_LEVEL_LSB 0
`define REG_LEVEL_MSB 4
`define REG_DISABLE_BIT 5
`define REG_BYPASS_BIT 6
`define STAT_LOCKED_BIT 8
`define STAT_MACT_LSB 16
`define STAT_MACT_MSB 20
`define LOCK_LSB 0
`define LOCK_MSB 15

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MULT_RESET 5'h0a
`define SYSDIV_RESET 4'h5
`define COREDIV_RESET 2'h0
`define REG_LEVEL_RESET 5'h0a
`define LOCK_COUNT_RESET 16'h0200

// ----------------------------------------
// Operating modes and mode commands
// ----------------------------------------
`define MODE_FULL_ON 2'h0
`define MODE_ACTIVE 2'h1
`define MODE_SLEEP 2'h2
`define MODE_DEEP_SLEEP 2'h3
`define CMD_SLEEP 2'h1
`define CMD_DEEP_SLEEP 2'h2

// ----------------------------------------
// Regulator step size
// ----------------------------------------
`define REG_STEP_MV 50

`endif

// ### test/pmcm_props.sv
// Checker for the power mode and clock manager ports.
// Assumes binding to power_mode_clock_manager, one clock domain.
`timescale 1ns/1ns
`default_nettype none
`include "pwr_clk_defines.vh"
module pmcm_props (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  // Modes and grants
  input wire dma_req,
  input wire dma_grant,
  input wire rtc_access_grant,
  input wire core_clk,
  input wire system_clk,
  input wire pll_enable,
  input wire pll_bypass,
  input wire [1:0] op_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [4:0] slp;
  // ----------------------------------------
  // Sleep length, saturating
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) slp <= 5'h00;
    else if (op_mode != `MODE_SLEEP) slp <= 5'h00;
    else if (slp != 5'h1f) slp <= slp + 5'h01;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_full_on_pll: assert property (
    (op_mode == `MODE_FULL_ON) [*2] |-> pll_enable && !pll_bypass) else $error("pll off");
  a_active_bypass: assert property (
    (op_mode == `MODE_ACTIVE) [*2] |-> pll_bypass) else $error("no bypass");
  a_dma_on: assert property (
    (op_mode <= `MODE_ACTIVE && dma_req) ##1 (op_mode <= `MODE_ACTIVE) |-> dma_grant)
    else $error("dma refused");
  a_core_gated: assert property (
    slp > 5'h12 |-> !core_clk) else $error("core clock in sleep");
  a_sleep_wake: assert property (
    $past(op_mode) == `MODE_SLEEP && op_mode != `MODE_SLEEP |-> op_mode <= `MODE_ACTIVE)
    else $error("bad wake");
  a_dma_sleep: assert property (
    (op_mode == `MODE_SLEEP) [*2] |-> !dma_grant) else $error("dma in sleep");
  a_deep_pll: assert property (
    (op_mode == `MODE_DEEP_SLEEP && !core_clk && !system_clk) [*2] |-> !pll_enable)
    else $error("pll on");
  a_deep_clk_low: assert property (
    $rose(op_mode == `MODE_DEEP_SLEEP) |-> ##[0:20]
    ((!core_clk && !system_clk && !pll_enable) || op_mode != `MODE_DEEP_SLEEP))
    else $error("clocks left running in deep sleep");
  a_deep_exit: assert property (
    $past(op_mode) == `MODE_DEEP_SLEEP && op_mode != `MODE_DEEP_SLEEP
    |-> op_mode == `MODE_FULL_ON) else $error("bad deep exit");
  a_deep_rtc: assert property (
    (op_mode == `MODE_DEEP_SLEEP) [*2] |-> !rtc_access_grant) else $error("rtc access");
  a_apb_answer: assert property (
    psel && penable && !pready |=> pready) else $error("late pready");
  c_sleep_active: cover property (op_mode == `MODE_SLEEP ##1 op_mode == `MODE_ACTIVE);
  c_deep_full: cover property (op_mode == `MODE_DEEP_SLEEP ##1 op_mode == `MODE_FULL_ON);
  c_apb: cover property (pready);
endmodule
bind power_mode_clock_manager pmcm_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .dma_req(dma_req),
  .dma_grant(dma_grant), .rtc_access_grant(rtc_access_grant), .core_clk(core_clk),
  .system_clk(system_clk), .pll_enable(pll_enable),
  .pll_bypass(pll_bypass), .op_mode(op_mode));
`default_nettype wire

// ### test/tb_top.sv
// Testbench for the power mode and clock manager.
// Assumes the design's defines header is on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "pwr_clk_defines.vh"
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic input_clk_pin = 1'b0;
  logic wake_irq = 1'b0;
  logic rtc_wake_irq = 1'b0;
  logic reset_wake_irq = 1'b0;
  logic dma_req = 1'b1;
  logic rtc_access_req = 1'b1;
  wire [31:0] prdata;
  wire [4:0] regulator_level;
  wire [1:0] op_mode;
  wire pready, pslverr, dma_grant, rtc_access_grant, core_clk, system_clk;
  wire pll_enable, pll_bypass, regulator_enable, regulator_bypass;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  int sv[4] = '{1, 6, 15, 2};
  power_mode_clock_manager DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .input_clk_pin, .wake_irq, .rtc_wake_irq,
    .reset_wake_irq, .dma_req, .rtc_access_req, .dma_grant, .rtc_access_grant,
    .core_clk, .system_clk, .pll_enable, .pll_bypass, .regulator_level,
    .regulator_enable, .regulator_bypass, .op_mode);
  // ----------------------------------------
  // Clocks and hang guard
  // ----------------------------------------
  always #50 pclk = ~pclk;
  // Three pclk periods, phase unrelated to pclk
  initial begin
    #37;
    forever #150 input_clk_pin = ~input_clk_pin;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Read just after the edge, before the design's own updates land
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, a > `OFS_STATUS});
  endtask
  // Rising edge to rising edge, in pclk cycles; first edge skipped
  task per(input logic c, output int p);
    longint t;
    repeat (2) if (c) @(posedge core_clk); else @(posedge system_clk);
    t = $time;
    if (c) @(posedge core_clk); else @(posedge system_clk);
    p = int'(($time - t) / 100);
  endtask
  task tick(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    tick(8);
    presetn <= 1'b1;
    tick(6);
    chk(op_mode, `MODE_FULL_ON);
    chk({pll_enable, pll_bypass, dma_grant}, 3'b101);
    chk(regulator_level, `REG_LEVEL_RESET);
    dma_req <= 1'b0;
    tick(2);
    chk(dma_grant, 1'b0);
    dma_req <= 1'b1;
    rd(`OFS_PLL_CTRL, 32'h14);
    rd(`OFS_DIVIDE, 32'h05);
    rd(8'h18, 32'h0);
    wr(`OFS_LOCK_COUNT, 32'h8);
    wr(`OFS_PLL_CTRL, 32'h06);
    rd(`OFS_STATUS, 32'h000a0000);
    tick(12);
    rd(`OFS_STATUS, 32'h00030100);
    wr(`OFS_PLL_CTRL, 32'h0);
    rd(`OFS_PLL_CTRL, 32'h06);
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_DIVIDE, (i << 4) | sv[i]);
      per(1'b1, n);
      chk(n, 2 << i);
      per(1'b0, n);
      chk(n, 2 * sv[i]);
    end
    wr(`OFS_DIVIDE, 32'h0);
    rd(`OFS_DIVIDE, 32'h02);
    wr(`OFS_PLL_CTRL, 32'h07);
    tick(3);
    chk({op_mode, pll_bypass, dma_grant}, {`MODE_ACTIVE, 2'b11});
    per(1'b1, n);
    chk(n, 3);
    wr(`OFS_MODE, `CMD_SLEEP);
    tick(30);
    chk({op_mode, dma_grant, core_clk}, {`MODE_SLEEP, 2'b00});
    wake_irq <= 1'b1;
    tick(6);
    chk(op_mode, `MODE_ACTIVE);
    wake_irq <= 1'b0;
    wr(`OFS_PLL_CTRL, 32'h06);
    wr(`OFS_MODE, `CMD_SLEEP);
    tick(30);
    per(1'b0, n);
    chk(n, 4);
    wake_irq <= 1'b1;
    tick(6);
    chk(op_mode, `MODE_FULL_ON);
    wr(`OFS_MODE, `CMD_DEEP_SLEEP);
    tick(10);
    chk({op_mode, pll_enable, rtc_access_grant}, {`MODE_DEEP_SLEEP, 2'b00});
    rtc_wake_irq <= 1'b1;
    tick(6);
    chk({op_mode, rtc_access_grant}, {`MODE_FULL_ON, 1'b1});
    rtc_wake_irq <= 1'b0;
    wr(`OFS_MODE, `CMD_DEEP_SLEEP);
    tick(10);
    chk(op_mode, `MODE_DEEP_SLEEP);
    reset_wake_irq <= 1'b1;
    tick(6);
    chk(op_mode, `MODE_FULL_ON);
    wr(`OFS_REGULATOR, 32'h67);
    rd(`OFS_REGULATOR, 32'h67);
    chk({regulator_level, regulator_enable, regulator_bypass}, 7'h1d);
    tally_and_finish;
  end
endmodule
`default_nettype wire
